// File: word_codec_pkg.sv
/*
  package for the serial register word decoder: word layout, page fields,
  burst sample framing and timing constants.
  assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
`default_nettype none
package word_codec_pkg;
  // ********************************************************
  // word layout
  // ********************************************************
  localparam int WORD_W = 16;
  localparam int DATA_W = 10;
  localparam int ADDR_W = 5;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 6;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int SAMPLE_W = 15;
  localparam int PAGE_W = 2;
  localparam int NUM_PAGES = 4;
  localparam int NUM_ADDRS = 32;
  localparam int NUM_REGS = NUM_PAGES * NUM_ADDRS;
  localparam int REG_IDX_W = 7;
  localparam logic [DATA_W-1:0] REG_RESET = 10'h000;
  // page select register sits at page 1 address 1, also mirrored on page 0
  localparam logic [ADDR_W-1:0] PAGE_REG_ADDR = 5'h01;
  localparam logic [ADDR_W-1:0] RSVD_ADDR = 5'h00;
  localparam int BB_PAGE_LSB = 2;
  localparam int MICRO_PAGE_LSB = 0;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h0;
  localparam logic [PAGE_W-1:0] LAST_MAPPED_PAGE = 2'h1;
  // ********************************************************
  // burst timing
  // ********************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int BIT_RATE_HZ = 13_000_000;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam int GAP_BITS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 8;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GAP} tx_state_e;
endpackage : word_codec_pkg
`default_nettype wire

// File: sample_bus_if.sv
/*
  interface carrying sample words between the burst fifo and the shifter.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sample_bus_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sample_bus_if
`default_nettype wire

// File: sample_fifo.sv
/*
  flip-flop fifo, valid/ready on both sides, honest full and empty.
  assumes synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  sample_bus_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out.valid = (cnt_q != '0);
  assign out.data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: burst_shifter.sv
/*
  shifts burst sample words msb first, one bit per 7-cycle bit period (about 14.3 MHz),
  with a one-word idle gap between words.
  assumes the fifo presents words on the sample bus.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_shifter
  import word_codec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  sample_bus_if.snk in,
  output logic tx_data,
  output logic tx_frame
);
  tx_state_e state_q;
  logic [WORD_W-1:0] sh_q;
  logic [CNT_W-1:0] div_q;
  logic [CNT_W-1:0] bit_q;
  logic tick;
  assign tick = (div_q == CNT_W'(BIT_CYCLES - 1));
  assign in.ready = (state_q == TX_IDLE);
  always_ff @(posedge ref_clk) begin
    if (rst || state_q == TX_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= TX_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      tx_data <= 1'b0;
      tx_frame <= 1'b0;
    end else begin
      case (state_q)
        TX_IDLE: begin
          tx_data <= 1'b0;
          tx_frame <= 1'b0;
          if (in.valid) begin
            sh_q <= in.data;
            bit_q <= '0;
            state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          tx_frame <= 1'b1;
          tx_data <= sh_q[WORD_W-1];
          if (tick) begin
            sh_q <= {sh_q[WORD_W-2:0], 1'b0};
            if (bit_q == CNT_W'(WORD_W - 1)) begin
              bit_q <= '0;
              state_q <= TX_GAP;
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        TX_GAP: begin
          tx_frame <= 1'b0;
          tx_data <= 1'b0;
          if (tick) begin
            if (bit_q == CNT_W'(GAP_BITS - 1)) begin
              state_q <= TX_IDLE;
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= TX_IDLE;
        end
      endcase
    end
  end
endmodule : burst_shifter
`default_nettype wire

// File: serial_register_word_decoder.sv
/*
  decodes 16-bit register access words from the baseband and micro ports,
  holds the register bank and page select, and frames burst sample words.
  assumes words arrive already deserialised, synchronous to ref_clk.
*/
// Overview of operation
// - each access is one 16-bit word
// - bits 15..6 carry ten data bits
// - bits 5..1 address, combined with page
// - bit 0 low writes, high reads
// - write loads data into addressed register
// - read ignores the data field
// - both ports decode identically
// - burst word: 15-bit sample, bit 0 I/Q
// - burst bits shift every 7 cycles, about 14.3 Mbps
// - one word gap between burst words
// - page register holds per-port page fields
`timescale 1ns/1ps
`default_nettype none
module serial_register_word_decoder
  import word_codec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bb_word_valid,
  input wire logic [WORD_W-1:0] bb_word,
  output logic bb_rd_valid,
  output logic [WORD_W-1:0] bb_rd_word,
  input wire logic micro_word_valid,
  input wire logic [WORD_W-1:0] micro_word,
  output logic micro_rd_valid,
  output logic [WORD_W-1:0] micro_rd_word,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_value,
  input wire logic sample_is_q,
  output logic sample_ready,
  output logic burst_tx_data,
  output logic burst_tx_frame,
  output logic [PAGE_W-1:0] bb_page,
  output logic [PAGE_W-1:0] micro_page
);
  // ********************************************************
  // word field helpers
  // ********************************************************
  // data field
  function automatic logic [DATA_W-1:0] word_data(input logic [WORD_W-1:0] w);
    return w[DATA_MSB:DATA_LSB];
  endfunction : word_data

  function automatic logic [ADDR_W-1:0] word_addr(input logic [WORD_W-1:0] w);
    return w[ADDR_MSB:ADDR_LSB];
  endfunction : word_addr

  function automatic logic word_is_read(input logic [WORD_W-1:0] w);
    return w[RW_BIT];
  endfunction : word_is_read

  // mapped map: pages 0 and 1, address 0 reserved
  function automatic logic is_mapped(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] a);
    return (pg <= LAST_MAPPED_PAGE) && (a != RSVD_ADDR);
  endfunction : is_mapped

  function automatic logic [REG_IDX_W-1:0] reg_index(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] a);
    return {pg, a};
  endfunction : reg_index

  // two-bit page field of a page write
  function automatic logic [PAGE_W-1:0] page_field(input logic [WORD_W-1:0] w, input int lsb);
    return w[DATA_LSB+lsb +: PAGE_W];
  endfunction : page_field

  // ********************************************************
  // storage
  // ********************************************************
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic [PAGE_W-1:0] bb_page_q;
  logic [PAGE_W-1:0] micro_page_q;
  logic [DATA_W-1:0] page_view;
  logic [DATA_W-1:0] bb_data;
  logic [ADDR_W-1:0] bb_addr;
  logic [REG_IDX_W-1:0] bb_idx;
  logic bb_mapped;
  logic bb_pg_hit;
  logic bb_rd;
  logic bb_wr;
  logic [DATA_W-1:0] bb_rd_data;
  logic [DATA_W-1:0] micro_data;
  logic [ADDR_W-1:0] micro_addr;
  logic [REG_IDX_W-1:0] micro_idx;
  logic micro_mapped;
  logic micro_pg_hit;
  logic micro_rd;
  logic micro_wr;
  logic [DATA_W-1:0] micro_rd_data;
  logic page_wr;
  logic [PAGE_W-1:0] page_bb_d;
  logic [PAGE_W-1:0] page_micro_d;

  assign bb_page = bb_page_q;
  assign micro_page = micro_page_q;

  // ********************************************************
  // page read view
  // ********************************************************
  // page register reads back both fields, upper bits zero
  assign page_view = DATA_W'({bb_page_q, micro_page_q});

  // ********************************************************
  // baseband port decode
  // ********************************************************
  // same decode on both ports
  always_comb begin
    bb_data = word_data(bb_word);
    bb_addr = word_addr(bb_word);
    bb_idx = reg_index(bb_page_q, bb_addr);
    bb_mapped = is_mapped(bb_page_q, bb_addr);
    bb_pg_hit = (bb_addr == PAGE_REG_ADDR);
    bb_rd = bb_word_valid && word_is_read(bb_word);
    bb_wr = bb_word_valid && !word_is_read(bb_word) && bb_mapped;
  end

  always_comb begin
    bb_rd_data = '0;
    if (bb_mapped) begin
      if (bb_pg_hit) begin
        bb_rd_data = page_view;
      end else begin
        bb_rd_data = regs_q[bb_idx];
      end
    end
  end

  // ********************************************************
  // micro port decode
  // ********************************************************
  // same decode on both ports
  always_comb begin
    micro_data = word_data(micro_word);
    micro_addr = word_addr(micro_word);
    micro_idx = reg_index(micro_page_q, micro_addr);
    micro_mapped = is_mapped(micro_page_q, micro_addr);
    micro_pg_hit = (micro_addr == PAGE_REG_ADDR);
    micro_rd = micro_word_valid && word_is_read(micro_word);
    micro_wr = micro_word_valid && !word_is_read(micro_word) && micro_mapped;
  end

  always_comb begin
    micro_rd_data = '0;
    if (micro_mapped) begin
      if (micro_pg_hit) begin
        micro_rd_data = page_view;
      end else begin
        micro_rd_data = regs_q[micro_idx];
      end
    end
  end

  // ********************************************************
  // register writes
  // ********************************************************
  // micro port wins a same-cycle collision on one register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else begin
      if (bb_wr && !bb_pg_hit) begin
        regs_q[bb_idx] <= bb_data;
      end
      if (micro_wr && !micro_pg_hit) begin
        regs_q[micro_idx] <= micro_data;
      end
    end
  end

  // ********************************************************
  // page select register
  // ********************************************************
  // micro port wins a same-cycle page write
  // a port parked on page 2 or 3 needs the other port to move it back
  always_comb begin
    page_wr = 1'b0;
    page_bb_d = bb_page_q;
    page_micro_d = micro_page_q;
    if (micro_wr && micro_pg_hit) begin
      page_wr = 1'b1;
      page_bb_d = page_field(micro_word, BB_PAGE_LSB);
      page_micro_d = page_field(micro_word, MICRO_PAGE_LSB);
    end else if (bb_wr && bb_pg_hit) begin
      page_wr = 1'b1;
      page_bb_d = page_field(bb_word, BB_PAGE_LSB);
      page_micro_d = page_field(bb_word, MICRO_PAGE_LSB);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bb_page_q <= PAGE_RESET;
      micro_page_q <= PAGE_RESET;
    end else if (page_wr) begin
      bb_page_q <= page_bb_d;
      micro_page_q <= page_micro_d;
    end
  end

  // ********************************************************
  // read answers
  // ********************************************************
  // data field of a read is never looked at
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bb_rd_valid <= 1'b0;
      bb_rd_word <= '0;
    end else begin
      bb_rd_valid <= bb_rd;
      if (bb_rd) begin
        bb_rd_word <= {bb_rd_data, bb_addr, 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      micro_rd_valid <= 1'b0;
      micro_rd_word <= '0;
    end else begin
      micro_rd_valid <= micro_rd;
      if (micro_rd) begin
        micro_rd_word <= {micro_rd_data, micro_addr, 1'b1};
      end
    end
  end

  // ********************************************************
  // burst sample path
  // ********************************************************
  // fifo absorbs samples while the shifter sits in the gap
  sample_bus_if sbus ();
  logic [WORD_W-1:0] sample_word;
  // sample in 15..1, i/q flag in bit 0
  assign sample_word = {sample_value, sample_is_q};

  sample_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_word),
    .out(sbus.src)
  );

  burst_shifter u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .in(sbus.snk),
    .tx_data(burst_tx_data),
    .tx_frame(burst_tx_frame)
  );
endmodule : serial_register_word_decoder
`default_nettype wire

// File: serial_register_word_decoder_chk.sv
/* port checker for the register word decoder.
   assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module serial_register_word_decoder_chk
  import word_codec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bb_word_valid,
  input wire logic [WORD_W-1:0] bb_word,
  input wire logic bb_rd_valid,
  input wire logic [WORD_W-1:0] bb_rd_word,
  input wire logic micro_word_valid,
  input wire logic [WORD_W-1:0] micro_word,
  input wire logic micro_rd_valid,
  input wire logic [PAGE_W-1:0] micro_page,
  input wire logic burst_tx_data,
  input wire logic burst_tx_frame
);
  localparam int FRAME_CYC = WORD_W * BIT_CYCLES;
  localparam int GAP_CYC = GAP_BITS * BIT_CYCLES;
  logic [CNT_W-1:0] hi_q;
  logic [CNT_W-1:0] lo_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // run lengths of frame high and low; low saturates so a start after reset passes
  // ****
  always_ff @(posedge ref_clk) begin
    hi_q <= (rst || !burst_tx_frame) ? 8'h00 : hi_q + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    lo_q <= rst ? 8'hFF : (burst_tx_frame ? 8'h00 : (lo_q == 8'hFF ? lo_q : lo_q + 8'h01));
  end
  sequence s_bb_rd;
    bb_word_valid && bb_word[RW_BIT];
  endsequence
  property p_bb_ans;
    s_bb_rd |=> bb_rd_valid && bb_rd_word[RW_BIT] && bb_rd_word[ADDR_MSB:ADDR_LSB] == $past(bb_word[ADDR_MSB:ADDR_LSB]);
  endproperty
  a_bb_ans: assert property (p_bb_ans) else $error("read answer wrong");
  property p_bb_quiet;
    !(bb_word_valid && bb_word[RW_BIT]) |=> !bb_rd_valid;
  endproperty
  a_bb_quiet: assert property (p_bb_quiet) else $error("answer without read");
  property p_mc_ans;
    micro_word_valid && micro_word[RW_BIT] |=> micro_rd_valid;
  endproperty
  a_mc_ans: assert property (p_mc_ans) else $error("micro read unanswered");
  property p_mc_quiet;
    !(micro_word_valid && micro_word[RW_BIT]) |=> !micro_rd_valid;
  endproperty
  a_mc_quiet: assert property (p_mc_quiet) else $error("micro answer without read");
  property p_rsvd;
    s_bb_rd ##0 bb_word[ADDR_MSB:ADDR_LSB] == RSVD_ADDR |=> bb_rd_word[DATA_MSB:DATA_LSB] == 10'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_page;
    micro_word_valid && !micro_word[RW_BIT] && micro_word[ADDR_MSB:ADDR_LSB] == PAGE_REG_ADDR
      && micro_page <= LAST_MAPPED_PAGE |=> micro_page == $past(micro_word[DATA_LSB+1:DATA_LSB]);
  endproperty
  a_page: assert property (p_page) else $error("micro page not loaded");
  property p_len;
    $fell(burst_tx_frame) |-> hi_q == FRAME_CYC;
  endproperty
  a_len: assert property (p_len) else $error("burst word length wrong");
  property p_hold;
    burst_tx_frame && hi_q != 8'h00 && hi_q % BIT_CYCLES != 0 |-> $stable(burst_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("bit changed mid period");
  property p_gap;
    $rose(burst_tx_frame) |-> lo_q >= GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short");
endmodule : serial_register_word_decoder_chk
`default_nettype wire

// File: burst_rx_model.sv
/* far-side receiver of burst sample words.
   assumes frame high for exactly one word. */
`timescale 1ns/1ps
`default_nettype none
module burst_rx_model
  import word_codec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_data,
  input wire logic tx_frame,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_stb
);
  int cyc;
  logic [WORD_W-1:0] sh;
  initial rx_stb = 1'b0;
  always @(posedge ref_clk) begin
    rx_stb <= 1'b0;
    if (rst || !tx_frame) begin
      cyc = 0;
    end else begin
      if (cyc % BIT_CYCLES == BIT_CYCLES / 2) begin
        sh = {sh[WORD_W-2:0], tx_data};
        if (cyc / BIT_CYCLES == WORD_W - 1) begin
          rx_word <= sh;
          rx_stb <= 1'b1;
        end
      end
      cyc++;
    end
  end
endmodule : burst_rx_model
`default_nettype wire

// File: serial_register_word_decoder_tb_top.sv
/* self-checking bench for the register word decoder.
   assumes the far-side model and the port checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module serial_register_word_decoder_tb_top
  import word_codec_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic bb_word_valid = 1'b0;
  logic micro_word_valid = 1'b0;
  logic sample_valid = 1'b0;
  logic sample_is_q = 1'b0;
  logic [WORD_W-1:0] bb_word = 16'h0000;
  logic [WORD_W-1:0] micro_word = 16'h0000;
  logic [SAMPLE_W-1:0] sample_value = 15'h0000;
  logic bb_rd_valid, micro_rd_valid, sample_ready, burst_tx_data, burst_tx_frame, rx_stb, took;
  logic [WORD_W-1:0] bb_rd_word, micro_rd_word, rx_word;
  logic [PAGE_W-1:0] bb_page, micro_page;
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] exp_w;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  serial_register_word_decoder i_dut (.ref_clk(ref_clk), .rst(rst), .bb_word_valid(bb_word_valid),
    .bb_word(bb_word), .bb_rd_valid(bb_rd_valid), .bb_rd_word(bb_rd_word),
    .micro_word_valid(micro_word_valid), .micro_word(micro_word), .micro_rd_valid(micro_rd_valid),
    .micro_rd_word(micro_rd_word), .sample_valid(sample_valid), .sample_value(sample_value),
    .sample_is_q(sample_is_q), .sample_ready(sample_ready), .burst_tx_data(burst_tx_data),
    .burst_tx_frame(burst_tx_frame), .bb_page(bb_page), .micro_page(micro_page));
  burst_rx_model i_far (.ref_clk(ref_clk), .rst(rst), .tx_data(burst_tx_data),
    .tx_frame(burst_tx_frame), .rx_word(rx_word), .rx_stb(rx_stb));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("compared %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // one word, valid for one cycle; ends just after the taking edge
  task automatic acc(input logic mp, input logic [9:0] d, input logic [4:0] a, input logic r);
    @(posedge ref_clk);
    if (mp) begin
      micro_word_valid <= 1'b1;
      micro_word <= {d, a, r};
    end else begin
      bb_word_valid <= 1'b1;
      bb_word <= {d, a, r};
    end
    @(posedge ref_clk);
    bb_word_valid <= 1'b0;
    micro_word_valid <= 1'b0;
    #1;
  endtask : acc
  // junk in the data field must not leak into the answer
  task automatic rd(input logic mp, input logic [4:0] a, input logic [9:0] d);
    acc(mp, 10'h3FF, a, 1'b1);
    `CHK(mp ? micro_rd_valid : bb_rd_valid, 1'b1)
    `CHK(mp ? micro_rd_word : bb_rd_word, {d, a, 1'b1})
  endtask : rd
  // ****
  // far-side word compare and hang guard
  // ****
  always @(posedge ref_clk) begin
    cyc++;
    if (rx_stb) begin
      `CHK(exp_q.size() != 0, 1'b1)
      // pop once, so a mismatch print cannot eat a second word
      if (exp_q.size() != 0) exp_w = exp_q.pop_front();
      else exp_w = '0;
      `CHK(rx_word, exp_w)
    end
    if (cyc == 10000) begin
      error_cnt++;
      $display("mismatch t=%0t timeout", $time);
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    `CHK({sample_ready, bb_page, micro_page}, 5'h10)
    acc(1'b0, 10'h2A5, 5'h05, 1'b0);
    rd(1'b0, 5'h05, 10'h2A5);
    rd(1'b1, 5'h05, 10'h2A5);
    acc(1'b1, 10'h15A, 5'h05, 1'b0);
    rd(1'b0, 5'h05, 10'h15A);
    acc(1'b0, 10'h3FF, RSVD_ADDR, 1'b0);
    rd(1'b0, RSVD_ADDR, 10'h000);
    acc(1'b0, 10'h008, PAGE_REG_ADDR, 1'b0);
    `CHK({bb_page, micro_page}, 4'h8)
    acc(1'b0, 10'h111, 5'h05, 1'b0);
    rd(1'b0, 5'h05, 10'h000);
    rd(1'b1, 5'h05, 10'h15A);
    acc(1'b1, 10'h001, PAGE_REG_ADDR, 1'b0);
    `CHK({bb_page, micro_page}, 4'h1)
    acc(1'b1, 10'h0F0, 5'h05, 1'b0);
    rd(1'b1, 5'h05, 10'h0F0);
    rd(1'b0, 5'h05, 10'h15A);
    $display("register test done");
    // fill until refused; the shifter drains slowly meanwhile
    i = 0;
    took = 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sample_value <= 15'h7FFF;
    while (took && i < 40) begin
      @(negedge ref_clk);
      took = sample_ready;
      @(posedge ref_clk);
      if (took) begin
        exp_q.push_back({sample_value, sample_is_q});
        i++;
        sample_value <= 15'((i * 32'h0000_0913) ^ 32'h0000_5A5A);
        sample_is_q <= ~sample_is_q;
      end
    end
    sample_valid <= 1'b0;
    `CHK(i >= FIFO_DEPTH && i <= FIFO_DEPTH + 2, 1'b1)
    while (exp_q.size() != 0) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    $display("burst test done");
    conclude();
  end
endmodule : serial_register_word_decoder_tb_top
bind serial_register_word_decoder serial_register_word_decoder_chk i_chk (.ref_clk(ref_clk), .rst(rst),
  .bb_word_valid(bb_word_valid), .bb_word(bb_word), .bb_rd_valid(bb_rd_valid), .bb_rd_word(bb_rd_word),
  .micro_word_valid(micro_word_valid), .micro_word(micro_word), .micro_rd_valid(micro_rd_valid),
  .micro_page(micro_page), .burst_tx_data(burst_tx_data), .burst_tx_frame(burst_tx_frame));
`undef CHK
`default_nettype wire
